// ---- inc/dir_pkg.sv ----
package dir_pkg;

   // register byte offsets
   localparam logic [7:0] DIR_OFS_CTRL     = 8'h00;
   localparam logic [7:0] DIR_OFS_CAPS     = 8'h04;
   localparam logic [7:0] DIR_OFS_CERT     = 8'h08;
   localparam logic [7:0] DIR_OFS_PROD     = 8'h0C;
   localparam logic [7:0] DIR_OFS_PTVDO    = 8'h10;
   localparam logic [7:0] DIR_OFS_STATUS   = 8'h14;
   localparam logic [7:0] DIR_OFS_HDR      = 8'h18;

   // identity header field positions
   localparam int DIR_HOST_BIT   = 31;
   localparam int DIR_DEV_BIT    = 30;
   localparam int DIR_UFP_LSB    = 27;
   localparam int DIR_MODAL_BIT  = 26;
   localparam int DIR_DFP_LSB    = 23;
   localparam int DIR_VID_LSB    = 0;

   // caps register field positions
   localparam int DIR_CAP_VID_LSB   = 0;
   localparam int DIR_CAP_UFP_LSB   = 16;
   localparam int DIR_CAP_DFP_LSB   = 19;
   localparam int DIR_CAP_HOST_BIT  = 22;
   localparam int DIR_CAP_DEV_BIT   = 23;
   localparam int DIR_CAP_MODAL_BIT = 24;
   localparam int DIR_CAP_PLUG_BIT  = 25;
   localparam int DIR_CAP_COND_BIT  = 26;
   localparam int DIR_CAP_ALT_BIT   = 27;

   localparam int DIR_CTRL_EN_BIT   = 0;

   // product-type codes
   localparam logic [2:0] DIR_UFP_UNDEF  = 3'h0;
   localparam logic [2:0] DIR_UFP_HUB    = 3'h1;
   localparam logic [2:0] DIR_UFP_PERIPH = 3'h2;
   localparam logic [2:0] DIR_UFP_AMA    = 3'h5;
   localparam logic [2:0] DIR_PLUG_UNDEF = 3'h0;
   localparam logic [2:0] DIR_PLUG_PASV  = 3'h3;
   localparam logic [2:0] DIR_PLUG_ACTV  = 3'h4;
   localparam logic [2:0] DIR_DFP_UNDEF  = 3'h0;
   localparam logic [2:0] DIR_DFP_HUB    = 3'h1;
   localparam logic [2:0] DIR_DFP_HOST   = 3'h2;
   localparam logic [2:0] DIR_DFP_BRICK  = 3'h3;
   localparam logic [2:0] DIR_DFP_AMC    = 3'h4;

   localparam logic [31:0] DIR_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] DIR_CAPS_RST  = 32'h0000_0000;
   localparam logic [31:0] DIR_ZERO32    = 32'h0000_0000;

   localparam logic [1:0] DIR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] DIR_RESP_SLVERR = 2'h2;

   // start-of-packet addressing of the incoming request
   localparam logic [1:0] DIR_SOP_PORT  = 2'h0;
   localparam logic [1:0] DIR_SOP_PRIME = 2'h1;

   localparam logic [2:0] DIR_CNT_HDR   = 3'h3;
   localparam logic [2:0] DIR_CNT_PT    = 3'h4;
   localparam logic [2:0] DIR_IDX_ZERO  = 3'h0;
   localparam logic [2:0] DIR_IDX_ONE   = 3'h1;

   typedef struct packed {
      logic        valid;
      logic [1:0]  sop;
   } dir_req_t;

   typedef struct packed {
      logic        valid;
      logic        last;
      logic [2:0]  index;
      logic [31:0] data;
   } dir_obj_t;

   typedef enum logic [3:0] {
      DIR_IDLE = 4'b0001,
      DIR_SEND = 4'b0010,
      DIR_DONE = 4'b0100,
      DIR_DROP = 4'b1000
   } dir_state_t;

endpackage

// ---- src/dir_responder.sv ----
`timescale 1ns/1ns
module dir_responder
   import dir_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire dir_req_t    req,
   output      dir_obj_t    obj,
   input  wire logic        obj_ready,
   output      logic        req_busy
);

   logic [31:0] ctrl_reg;
   logic [31:0] caps_reg;
   logic [31:0] cert_reg;
   logic [31:0] prod_reg;
   logic [31:0] ptvdo_reg;
   logic [7:0]  awaddr_reg;
   logic        aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        w_held_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   dir_state_t  state_reg;
   dir_state_t  state_next;
   logic [2:0]  idx_reg;
   logic [2:0]  idx_next;
   dir_obj_t    obj_reg;
   dir_obj_t    obj_next;
   logic [7:0]  answered_reg;
   logic [7:0]  dropped_reg;

   // capability inputs from software
   wire         cap_host  = caps_reg[DIR_CAP_HOST_BIT];
   wire         cap_dev   = caps_reg[DIR_CAP_DEV_BIT];
   wire         cap_modal = caps_reg[DIR_CAP_MODAL_BIT];
   wire         cap_plug  = caps_reg[DIR_CAP_PLUG_BIT];
   wire         cap_cond  = caps_reg[DIR_CAP_COND_BIT];
   wire         cap_alt   = caps_reg[DIR_CAP_ALT_BIT];
   wire [2:0]   cap_ufp   = caps_reg[DIR_CAP_UFP_LSB +: 3];
   wire [2:0]   cap_dfp   = caps_reg[DIR_CAP_DFP_LSB +: 3];
   wire [15:0]  cap_vid   = caps_reg[DIR_CAP_VID_LSB +: 16];

   // upstream type; alt-mode support forces the adapter code and
   // reserved codes fall back to undefined
   wire         ufp_legal = (cap_ufp == DIR_UFP_HUB)    ||
                            (cap_ufp == DIR_UFP_PERIPH) ||
                            (cap_ufp == DIR_UFP_AMA);
   wire [2:0]   ufp_type  = cap_alt ? DIR_UFP_AMA :
                            ufp_legal ? cap_ufp : DIR_UFP_UNDEF;
   wire [2:0]   plug_type = cap_cond ? DIR_PLUG_ACTV :
                            DIR_PLUG_PASV;
   wire [2:0]   up_field  = cap_plug ? plug_type : ufp_type;

   wire         dfp_legal = (cap_dfp == DIR_DFP_HUB)   ||
                            (cap_dfp == DIR_DFP_HOST)  ||
                            (cap_dfp == DIR_DFP_BRICK) ||
                            (cap_dfp == DIR_DFP_AMC);
   // a plug has no downstream role
   wire [2:0]   dfp_type  = cap_plug ? DIR_DFP_UNDEF :
                            (cap_alt && cap_host) ? DIR_DFP_AMC :
                            dfp_legal ? cap_dfp : DIR_DFP_UNDEF;

   logic [31:0] id_header;
   always_comb begin
      id_header = DIR_ZERO32;
      id_header[DIR_HOST_BIT]       = cap_host;
      id_header[DIR_DEV_BIT]        = cap_dev;
      id_header[DIR_UFP_LSB +: 3]   = up_field;
      id_header[DIR_MODAL_BIT]      = cap_modal | cap_alt;
      id_header[DIR_DFP_LSB +: 3]   = dfp_type;
      id_header[DIR_VID_LSB +: 16]  = cap_vid;
   end

   // product-type object needed: adapter/controller or any cable
   wire         pt_needed = cap_plug ||
                            (ufp_type == DIR_UFP_AMA) ||
                            (dfp_type == DIR_DFP_AMC);
   wire [2:0]   last_idx  = pt_needed ? DIR_CNT_PT - DIR_IDX_ONE :
                            DIR_CNT_HDR - DIR_IDX_ONE;
   // a plug, passive or active, only hears primed addressing
   wire         sop_ok    = cap_plug ? (req.sop == DIR_SOP_PRIME)
                                     : (req.sop == DIR_SOP_PORT);
   wire         enabled   = ctrl_reg[DIR_CTRL_EN_BIT];

   logic [31:0] obj_word;
   always_comb begin
      case (idx_reg)
         DIR_IDX_ZERO: obj_word = id_header;
         DIR_IDX_ONE:  obj_word = cert_reg;
         DIR_CNT_HDR - DIR_IDX_ONE: obj_word = prod_reg;
         default: obj_word = ptvdo_reg;
      endcase
   end

   wire obj_take = obj_reg.valid && obj_ready;

   always_comb begin
      state_next = state_reg;
      idx_next   = idx_reg;
      obj_next   = obj_reg;
      case (state_reg)
         DIR_IDLE: begin
            if (req.valid && enabled && sop_ok) begin
               state_next = DIR_SEND;
               idx_next   = DIR_IDX_ZERO;
            end else if (req.valid) begin
               state_next = DIR_DROP;
            end
         end
         DIR_SEND: begin
            if (!obj_reg.valid || obj_take) begin
               if (obj_reg.valid && obj_reg.last) begin
                  obj_next.valid = 1'b0;
                  state_next     = DIR_DONE;
               end else begin
                  obj_next.valid = 1'b1;
                  obj_next.index = idx_reg;
                  obj_next.data  = obj_word;
                  obj_next.last  = (idx_reg == last_idx);
                  idx_next       = idx_reg + DIR_IDX_ONE;
               end
            end
         end
         DIR_DONE: state_next = DIR_IDLE;
         DIR_DROP: state_next = DIR_IDLE;
         default:  state_next = DIR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         state_reg <= DIR_IDLE;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         idx_reg <= DIR_IDX_ZERO;
      else
         idx_reg <= idx_next;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         obj_reg <= '0;
      else
         obj_reg <= obj_next;
   end

   // eight-bit tallies wrap; software works with differences
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         answered_reg <= 8'h00;
      else if (state_reg == DIR_DONE)
         answered_reg <= answered_reg + 8'h01;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         dropped_reg <= 8'h00;
      else if (state_reg == DIR_DROP)
         dropped_reg <= dropped_reg + 8'h01;
   end

   assign obj      = obj_reg;
   assign req_busy = (state_reg != DIR_IDLE);

   // axi4-lite write: address and data accepted in either order
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   wire   aw_take  = s_axi_awvalid && s_axi_awready;
   wire   w_take   = s_axi_wvalid && s_axi_wready;
   wire   wr_go    = aw_held_reg && w_held_reg;
   wire   wr_ctrl  = wr_go && (awaddr_reg == DIR_OFS_CTRL);
   wire   wr_caps  = wr_go && (awaddr_reg == DIR_OFS_CAPS);
   wire   wr_cert  = wr_go && (awaddr_reg == DIR_OFS_CERT);
   wire   wr_prod  = wr_go && (awaddr_reg == DIR_OFS_PROD);
   wire   wr_ptvdo = wr_go && (awaddr_reg == DIR_OFS_PTVDO);
   wire   wr_hit   = wr_ctrl || wr_caps || wr_cert || wr_prod || wr_ptvdo;

   function automatic logic [31:0] dir_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction

   // each channel waits in its holding register for the other one, so
   // the master may offer address and data in either order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= DIR_ZERO32;
         wstrb_reg   <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_reg <= 1'b0;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // identity values are only changed by software; a change during an
   // answer would mix old and new objects, so software should idle first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         ctrl_reg <= DIR_CTRL_RST;
      else if (wr_ctrl)
         ctrl_reg <= dir_merge(ctrl_reg, wdata_reg, wstrb_reg);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         caps_reg <= DIR_CAPS_RST;
      else if (wr_caps)
         caps_reg <= dir_merge(caps_reg, wdata_reg, wstrb_reg);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         cert_reg <= DIR_ZERO32;
      else if (wr_cert)
         cert_reg <= dir_merge(cert_reg, wdata_reg, wstrb_reg);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         prod_reg <= DIR_ZERO32;
      else if (wr_prod)
         prod_reg <= dir_merge(prod_reg, wdata_reg, wstrb_reg);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         ptvdo_reg <= DIR_ZERO32;
      else if (wr_ptvdo)
         ptvdo_reg <= dir_merge(ptvdo_reg, wdata_reg, wstrb_reg);
   end

   // a new response outranks the clear of the one before it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         bvalid_reg <= 1'b0;
      else if (wr_go)
         bvalid_reg <= 1'b1;
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         bresp_reg <= DIR_RESP_OKAY;
      else if (wr_go)
         bresp_reg <= wr_hit ? DIR_RESP_OKAY : DIR_RESP_SLVERR;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // axi4-lite read
   assign s_axi_arready = !rvalid_reg;
   wire   ar_take  = s_axi_arvalid && s_axi_arready;
   wire [31:0] status_word = {8'h00, dropped_reg, answered_reg,
                              4'h0, state_reg};
   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = DIR_ZERO32;
      if (s_axi_araddr == DIR_OFS_CTRL)
         rd_word = ctrl_reg;
      else if (s_axi_araddr == DIR_OFS_CAPS)
         rd_word = caps_reg;
      else if (s_axi_araddr == DIR_OFS_CERT)
         rd_word = cert_reg;
      else if (s_axi_araddr == DIR_OFS_PROD)
         rd_word = prod_reg;
      else if (s_axi_araddr == DIR_OFS_PTVDO)
         rd_word = ptvdo_reg;
      else if (s_axi_araddr == DIR_OFS_STATUS)
         rd_word = status_word;
      else if (s_axi_araddr == DIR_OFS_HDR)
         rd_word = id_header;
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         rvalid_reg <= 1'b0;
      else if (ar_take)
         rvalid_reg <= 1'b1;
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= DIR_ZERO32;
         rresp_reg <= DIR_RESP_OKAY;
      end else if (ar_take) begin
         rdata_reg <= rd_word;
         rresp_reg <= rd_hit ? DIR_RESP_OKAY : DIR_RESP_SLVERR;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

endmodule

// ---- tb/dir_responder_checker.sv ----
`timescale 1ns/1ns
module dir_responder_checker
   import dir_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire dir_req_t   req,
   input wire dir_obj_t   obj,
   input wire logic       obj_ready,
   input wire logic       req_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic        hdr_pt;
   logic [31:0] h;
   assign h = obj.data;
   // the header decides whether a fourth word must follow
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         hdr_pt <= 1'b0;
      else if (obj.valid && obj.index == DIR_IDX_ZERO)
         hdr_pt <= h[29:27] inside {3'h3, 3'h4, 3'h5} || h[25:23] == 3'h4;
   end
   sequence s_take_last;
      obj.valid && obj_ready && obj.last;
   endsequence
   sequence s_wind_down;
      !obj.valid ##1 !req_busy;
   endsequence
   a_obj_latency: assert property ($rose(obj.valid) |->
      $past(req.valid, 2) && obj.index == DIR_IDX_ZERO)
      else $error("answer not two cycles after request");
   a_obj_stands: assert property (obj.valid && !obj_ready |=>
      $stable(obj)) else $error("object changed while stalled");
   a_idx_step: assert property (obj.valid && obj_ready && !obj.last |=>
      obj.valid && obj.index == $past(obj.index) + 3'h1)
      else $error("object index did not step by one");
   a_last_count: assert property (obj.valid && obj.last |->
      obj.index == (hdr_pt ? DIR_CNT_HDR : 3'h2))
      else $error("wrong number of objects");
   a_hdr_fields: assert property (obj.valid && obj.index == DIR_IDX_ZERO |->
      h[22:16] == 7'h00 && !(h[29:27] inside {3'h6, 3'h7}) &&
      h[25:23] <= DIR_DFP_AMC) else $error("header field out of range");
   a_modal_alt: assert property (obj.valid && obj.index == DIR_IDX_ZERO &&
      h[29:27] == DIR_UFP_AMA |-> h[DIR_MODAL_BIT])
      else $error("adapter without modal flag");
   a_wind_down: assert property (s_take_last |=> s_wind_down)
      else $error("responder did not return to idle");
   a_busy_hold: assert property (obj.valid |-> req_busy)
      else $error("object shown while idle");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
endmodule
bind dir_responder dir_responder_checker chk_u (.clk, .rstn, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .req, .obj, .obj_ready, .req_busy);

// ---- tb/dir_far_end.sv ----
`timescale 1ns/1ns
module dir_far_end
   import dir_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         go,
   input  wire logic [1:0]   sop_sel,
   input  wire logic         slow,
   input  wire logic         busy,
   output      dir_req_t     req,
   input  wire dir_obj_t     obj,
   output      logic         obj_ready,
   output      logic [127:0] words,
   output      logic [2:0]   n,
   output      logic         fin,
   output      logic         order_ok
);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         req <= '0;
         obj_ready <= 1'b0;
         words <= '0;
         n <= '0;
         fin <= 1'b0;
         order_ok <= 1'b1;
      end else begin
         req.valid <= go;
         // addressing is not held once the pulse is over
         req.sop <= go ? sop_sel : ~sop_sel;
         obj_ready <= slow ? !obj_ready : 1'b1;
         if (go && !busy) begin
            n <= '0;
            fin <= 1'b0;
            order_ok <= 1'b1;
         end else if (obj.valid && obj_ready) begin
            words[n*32 +: 32] <= obj.data;
            n <= n + 3'h1;
            fin <= obj.last;
            if (obj.index !== n)
               order_ok <= 1'b0;
         end
      end
   end
endmodule

// ---- tb/dir_responder_tb_top.sv ----
`timescale 1ns/1ns
module dir_responder_tb_top
   import dir_pkg::*;
;
   logic         clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic         awready, wready, bvalid, arready, rvalid;
   logic         go, slow, obj_ready, req_busy, fin, ook;
   logic [7:0]   awaddr, araddr;
   logic [31:0]  wdata, rdata, q, eh;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp, sop, r;
   logic [127:0] words;
   logic [2:0]   n, m;
   dir_req_t     req;
   dir_obj_t     obj;
   int           error_cnt, tests_run, i;
   logic [68:0]  rows [8];
   localparam logic [31:0] CERT = 32'hC0FFEE01;
   localparam logic [31:0] PROD = 32'h5A5A0304;
   localparam logic [31:0] PTW  = 32'h7E57DA7A;
   always #50 clk = ~clk;
   dir_responder dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req(req), .obj(obj),
      .obj_ready(obj_ready), .req_busy(req_busy));
   dir_far_end far_u (.clk(clk), .rstn(rstn), .go(go), .sop_sel(sop),
      .slow(slow), .busy(req_busy), .req(req), .obj(obj),
      .obj_ready(obj_ready), .words(words), .n(n), .fin(fin), .order_ok(ook));
   task automatic end_of_test;
      $display("mismatches %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // readies are read at the falling edge, so the handshake seen there
   // is the one taken at the next rising edge
   task automatic axi(input logic we, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] s);
      logic pa, pw, dn;
      int   k;
      pa = 1'b1;
      pw = we;
      dn = 1'b0;
      @(posedge clk);
      {awaddr, araddr, wdata, wstrb} <= {a, a, d, s};
      {awvalid, wvalid, arvalid} <= {we, we, !we};
      {bready, rready} <= {we, !we};
      for (k = 0; k < 40 && !dn; k++) begin
         @(negedge clk);
         if (pa && (we ? awready : arready))
            pa = 1'b0;
         if (pw && wready)
            pw = 1'b0;
         dn = we ? bvalid : rvalid;
         {q, r} = we ? {32'h0, bresp} : {rdata, rresp};
         @(posedge clk);
         {awvalid, wvalid, arvalid} <= {we && pa, pw, !we && pa};
         if (dn)
            {bready, rready} <= 2'h0;
      end
      if (!dn) begin
         error_cnt++;
         end_of_test;
      end
   endtask
   task automatic ask(input logic [1:0] s, input logic sl, input logic tw,
         input logic ans);
      int k;
      @(posedge clk);
      {go, sop, slow} <= {1'b1, s, sl};
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      go <= tw;
      @(posedge clk);
      go <= 1'b0;
      for (k = 0; k < 80 && ans && fin !== 1'b1; k++)
         @(negedge clk);
      if (k == 80) begin
         error_cnt++;
         end_of_test;
      end
      repeat (12) @(posedge clk);
      chk({31'h0, fin}, {31'h0, ans});
   endtask
   function automatic logic [31:0] exp_hdr(input logic [31:0] c);
      logic [2:0] u, d;
      u = c[18:16] inside {3'h3, 3'h4, 3'h6, 3'h7} ? DIR_UFP_UNDEF : c[18:16];
      d = c[21:19] > DIR_DFP_AMC ? DIR_DFP_UNDEF : c[21:19];
      if (c[27])
         u = DIR_UFP_AMA;
      if (c[27] && c[22])
         d = DIR_DFP_AMC;
      if (c[25])
         u = c[26] ? DIR_PLUG_ACTV : DIR_PLUG_PASV;
      if (c[25])
         d = DIR_DFP_UNDEF;
      return {c[22], c[23], u, c[24] | c[27], d, 7'h00, c[15:0]};
   endfunction
   initial begin
      {clk, rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {go, slow, sop, awaddr, araddr, wdata, wstrb} = '0;
      {error_cnt, tests_run} = '0;
      // addressing, caps word, expected header, expected object count
      rows = '{{2'h0, 32'h00D11234, 32'hC9001234, 3'h3},
               {2'h0, 32'h019AABCD, 32'h5580ABCD, 3'h3},
               {2'h0, 32'h00080001, 32'h00800001, 3'h3},
               {2'h0, 32'h08405555, 32'hAE005555, 3'h4},
               {2'h0, 32'h08000042, 32'h2C000042, 3'h4},
               {2'h1, 32'h02000777, 32'h18000777, 3'h4},
               {2'h1, 32'h06000888, 32'h20000888, 3'h4},
               {2'h0, 32'h003E0099, 32'h00000099, 3'h3}};
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      axi(1'b0, DIR_OFS_CTRL, '0, 4'hF);
      chk(q, DIR_CTRL_RST);
      axi(1'b0, DIR_OFS_CAPS, '0, 4'hF);
      chk(q, DIR_CAPS_RST);
      axi(1'b1, DIR_OFS_CTRL, 32'h1, 4'hF);
      axi(1'b1, DIR_OFS_CERT, CERT, 4'hF);
      axi(1'b1, DIR_OFS_PROD, 32'h5A5AFFFF, 4'hF);
      axi(1'b1, DIR_OFS_PROD, 32'hEEEE0304, 4'h3);
      axi(1'b1, DIR_OFS_PTVDO, PTW, 4'hF);
      for (i = 0; i < 8; i++) begin
         axi(1'b1, DIR_OFS_CAPS, rows[i][66:35], 4'hF);
         eh = rows[i][34:3];
         m = rows[i][2:0];
         axi(1'b0, DIR_OFS_HDR, '0, 4'hF);
         chk(q, eh);
         ask(rows[i][68:67], i[0], 1'b0, 1'b1);
         chk({29'h0, n}, {29'h0, m});
         chk(words[31:0], eh);
         chk(words[63:32], CERT);
         chk(words[95:64], PROD);
         if (m == DIR_CNT_PT)
            chk(words[127:96], PTW);
         chk({31'h0, ook}, 32'h1);
      end
      ask(DIR_SOP_PRIME, 1'b0, 1'b0, 1'b0);
      axi(1'b1, DIR_OFS_CAPS, rows[5][66:35], 4'hF);
      ask(DIR_SOP_PORT, 1'b0, 1'b0, 1'b0);
      ask(DIR_SOP_PRIME, 1'b1, 1'b1, 1'b1);
      chk({29'h0, n}, {29'h0, DIR_CNT_PT});
      axi(1'b1, DIR_OFS_HDR, 32'hFFFFFFFF, 4'hF);
      chk({30'h0, r}, {30'h0, DIR_RESP_SLVERR});
      axi(1'b0, DIR_OFS_HDR, '0, 4'hF);
      chk(q, exp_hdr(rows[5][66:35]));
      axi(1'b1, DIR_OFS_CTRL, 32'h0, 4'hF);
      ask(DIR_SOP_PRIME, 1'b0, 1'b0, 1'b0);
      axi(1'b0, DIR_OFS_STATUS, '0, 4'hF);
      chk(q, {8'h00, 8'h03, 8'h09, 4'h0, DIR_IDLE});
      axi(1'b0, 8'h40, '0, 4'hF);
      chk(q, DIR_ZERO32);
      chk({30'h0, r}, {30'h0, DIR_RESP_SLVERR});
      end_of_test;
   end
endmodule
